// >>> hw/scm_mode_regs.sv
// mode registers, clock selection and start sequencing for a two-channel serial unit
//
// Our own choice: register access over APB.
`timescale 1ns/1ps

module scm_mode_regs #(
    parameter int unsigned NCH = 2
) (
    input  wire logic                      CLOCK_I,
    input  wire logic                      RESET_I,
    input  wire logic                      PSEL_I,
    input  wire logic                      PENABLE_I,
    input  wire logic                      PWRITE_I,
    input  wire logic [31:0]               PADDR_I,
    input  wire logic [31:0]               PWDATA_I,
    input  wire logic [3:0]                PSTRB_I,
    output logic      [31:0]               PRDATA_O,
    output logic                           PREADY_O,
    output logic                           PSLVERR_O,
    input  wire logic                      SCK_PIN_I,
    input  wire logic                      RXD_PIN_I,
    input  wire logic [NCH-1:0]            XFER_END_I,
    input  wire logic [NCH-1:0]            BUF_EMPTY_I,
    output scm_pkg::scm_cfg_s [NCH-1:0]    CH_CFG_O,
    output scm_pkg::scm_chan_s [NCH-1:0]   CH_STAT_O,
    output logic                           IRQ_O
);
    // register state
    logic [15:0]                  mode_q [NCH];
    logic [15:0]                  data_q [NCH];
    logic [15:0]                  presc_q;
    logic [7:0]                   unit_q;
    logic [NCH-1:0]               irq_stat_q;
    logic [NCH-1:0]               irq_en_q;
    logic [31:0]                  prdata_q;
    scm_pkg::scm_chan_e           state_q [NCH];
    localparam int unsigned       PRESC_W_L = scm_pkg::PRESC_CNT_W;
    logic [PRESC_W_L-1:0]         presc_cnt_q;
    logic [7:0]                   div_cnt_q [NCH];
    logic [NCH-1:0]               op_tick_q;
    logic [NCH-1:0]               xfer_tick_q;
    logic [NCH-1:0]               start_q;
    logic                         sck_m_q, sck_s_q, sck_prev_q;
    logic                         rxd_m_q, rxd_s_q, rxd_prev_q;
    logic                         rx_data_q;

    // bus decode
    logic [19:0]                  idx;
    logic                         acc_wr;
    logic                         full_half;
    logic                         unit_en;
    logic                         mapped;
    logic [NCH-1:0]               op_tick_d;
    logic [NCH-1:0]               xfer_tick_d;
    logic [NCH-1:0]               trig_ok;
    logic [NCH-1:0]               irq_evt;
    logic                         sck_rise;
    logic                         rx_start_edge;

    assign idx       = PADDR_I[21:2];
    assign acc_wr    = PSEL_I & PENABLE_I & PWRITE_I;
    assign full_half = (PSTRB_I & scm_pkg::STRB_HALF) == scm_pkg::STRB_HALF;
    assign unit_en   = unit_q[scm_pkg::UNIT_EN_BIT];

    // true when the prescaler counter produces a tick for a 2^sel divider
    function automatic logic presc_tick(input logic [3:0] sel, input logic [14:0] cnt);
        logic [14:0] m;
        m = 15'h7FFF >> (4'hF - sel);
        presc_tick = (sel == 4'h0) ? 1'b1 : ((cnt & m) == m);
    endfunction

    // writable-bit mask per channel; channel 0 has no trigger or inversion bits
    function automatic logic [15:0] mode_mask(input int unsigned ch);
        mode_mask = (ch == 0) ? scm_pkg::MODE_MASK_CH0 : scm_pkg::MODE_MASK_CH1;
    endfunction

    always_comb begin
        case (idx)
            scm_pkg::IDX_UNIT, scm_pkg::IDX_MODE0, scm_pkg::IDX_MODE1, scm_pkg::IDX_PRESC,
            scm_pkg::IDX_START, scm_pkg::IDX_ENSTAT, scm_pkg::IDX_STOP, scm_pkg::IDX_DATA0,
            scm_pkg::IDX_DATA1, scm_pkg::IDX_IRQSTAT, scm_pkg::IDX_IRQCLR,
            scm_pkg::IDX_IRQEN: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // zero wait states: read data is captured in the setup cycle
    assign PREADY_O  = 1'b1;
    assign PRDATA_O  = prdata_q;
    assign PSLVERR_O = PSEL_I & PENABLE_I & (~mapped | (PWRITE_I & ~full_half));

    // read mux registered in the setup phase so read data comes from a flop
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            prdata_q <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            case (idx)
                scm_pkg::IDX_UNIT:    prdata_q <= {24'h000000, unit_q};
                scm_pkg::IDX_MODE0:   prdata_q <= {16'h0000, mode_q[0]};
                scm_pkg::IDX_MODE1:   prdata_q <= {16'h0000, mode_q[1]};
                scm_pkg::IDX_PRESC:   prdata_q <= {16'h0000, presc_q};
                scm_pkg::IDX_DATA0:   prdata_q <= {16'h0000, data_q[0]};
                scm_pkg::IDX_DATA1:   prdata_q <= {16'h0000, data_q[1]};
                scm_pkg::IDX_ENSTAT:  prdata_q <= {30'h0, state_q[1] != scm_pkg::SCM_IDLE,
                                                   state_q[0] != scm_pkg::SCM_IDLE};
                scm_pkg::IDX_IRQSTAT: prdata_q <= {30'h0, irq_stat_q};
                scm_pkg::IDX_IRQEN:   prdata_q <= {30'h0, irq_en_q};
                default:              prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // unit clock enable lives outside the gated group, so it is always writable
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            unit_q <= scm_pkg::UNIT_RESET;
        end else if (acc_wr && idx == scm_pkg::IDX_UNIT) begin
            unit_q <= PWDATA_I[7:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || !unit_en) begin
            presc_q <= scm_pkg::PRESC_RESET;
        end else if (acc_wr && full_half && idx == scm_pkg::IDX_PRESC) begin
            presc_q <= PWDATA_I[15:0];
        end
    end

    // free-running prescaler, held in reset while the unit clock is off
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I || !unit_en) begin
            presc_cnt_q <= '0;
        end else begin
            presc_cnt_q <= presc_cnt_q + 15'h0001;
        end
    end

    // pin synchronisers; only the second stage feeds logic
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            sck_m_q    <= 1'b0;
            sck_s_q    <= 1'b0;
            sck_prev_q <= 1'b0;
            rxd_m_q    <= 1'b1;
            rxd_s_q    <= 1'b1;
        end else begin
            sck_m_q    <= SCK_PIN_I;
            sck_s_q    <= sck_m_q;
            sck_prev_q <= sck_s_q;
            rxd_m_q    <= RXD_PIN_I;
            rxd_s_q    <= rxd_m_q;
        end
    end
    assign sck_rise = sck_s_q & ~sck_prev_q;

    // receive edge detector runs on channel 1 operation clock
    // start edge polarity follows the inversion bit
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            rxd_prev_q <= 1'b1;
            rx_data_q  <= 1'b1;
        end else if (op_tick_d[1]) begin
            rxd_prev_q <= rxd_s_q;
            rx_data_q  <= rxd_s_q ^ mode_q[1][scm_pkg::BIT_RX_INV];
        end
    end
    assign rx_start_edge = op_tick_d[1] & (rxd_prev_q != rxd_s_q)
                         & (mode_q[1][scm_pkg::BIT_RX_INV] ? rxd_s_q : ~rxd_s_q);

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic [15:0] m;
            assign m = mode_q[g];

            // operation clock from prescaler A or B
            assign op_tick_d[g] = unit_en & presc_tick(m[scm_pkg::BIT_CLK_SEL]
                ? presc_q[scm_pkg::PRESC_B_LSB +: scm_pkg::PRESC_SEL_W]
                : presc_q[scm_pkg::PRESC_A_LSB +: scm_pkg::PRESC_SEL_W], presc_cnt_q);

            // transfer clock from divider or external serial clock
            // one tick per 2*(ratio+1) op ticks
            assign xfer_tick_d[g] = m[scm_pkg::BIT_XFER_SRC] ? (unit_en & sck_rise)
                : (op_tick_d[g] && div_cnt_q[g] ==
                   {data_q[g][scm_pkg::RATIO_LSB +: scm_pkg::RATIO_W], 1'b1});

            always_ff @(posedge CLOCK_I) begin
                if (RESET_I || !unit_en || m[scm_pkg::BIT_XFER_SRC]) begin
                    div_cnt_q[g] <= 8'h00;
                end else if (xfer_tick_d[g]) begin
                    div_cnt_q[g] <= 8'h00;
                end else if (op_tick_d[g]) begin
                    div_cnt_q[g] <= div_cnt_q[g] + 8'h01;
                end
            end

            // channel 0 never arms on the receive pin
            // software trigger or receive start edge
            assign trig_ok[g] = !m[scm_pkg::BIT_TRIG_SRC] || (g == 1 && rx_start_edge);

            // reset value; defaults while unit off
            // enabled channel only takes the interrupt source bit
            // reserved bits pinned to fixed values
            always_ff @(posedge CLOCK_I) begin
                if (RESET_I || !unit_en) begin
                    mode_q[g] <= scm_pkg::MODE_RESET;
                end else if (acc_wr && full_half &&
                             idx == (g == 0 ? scm_pkg::IDX_MODE0 : scm_pkg::IDX_MODE1)) begin
                    if (state_q[g] != scm_pkg::SCM_IDLE) begin
                        mode_q[g] <= (m & ~scm_pkg::MODE_RUN_MASK)
                                   | (PWDATA_I[15:0] & scm_pkg::MODE_RUN_MASK);
                    end else begin
                        mode_q[g] <= (PWDATA_I[15:0] & mode_mask(g)) | scm_pkg::MODE_FIXED;
                    end
                end
            end

            // data register holds the divider ratio in its upper bits
            always_ff @(posedge CLOCK_I) begin
                if (RESET_I || !unit_en) begin
                    data_q[g] <= scm_pkg::DATA_RESET;
                end else if (acc_wr && full_half &&
                             idx == (g == 0 ? scm_pkg::IDX_DATA0 : scm_pkg::IDX_DATA1)) begin
                    data_q[g] <= PWDATA_I[15:0];
                end
            end

            // start waits in armed until the trigger is met
            always_ff @(posedge CLOCK_I) begin
                if (RESET_I || !unit_en) begin
                    state_q[g] <= scm_pkg::SCM_IDLE;
                    start_q[g] <= 1'b0;
                end else begin
                    start_q[g] <= 1'b0;
                    case (state_q[g])
                        scm_pkg::SCM_IDLE: begin
                            if (acc_wr && idx == scm_pkg::IDX_START && PWDATA_I[g]) begin
                                state_q[g] <= scm_pkg::SCM_ARMED;
                            end
                        end
                        scm_pkg::SCM_ARMED: begin
                            if (acc_wr && idx == scm_pkg::IDX_STOP && PWDATA_I[g]) begin
                                state_q[g] <= scm_pkg::SCM_IDLE;
                            end else if (trig_ok[g]) begin
                                state_q[g] <= scm_pkg::SCM_RUN;
                                start_q[g] <= 1'b1;
                            end
                        end
                        scm_pkg::SCM_RUN: begin
                            if (acc_wr && idx == scm_pkg::IDX_STOP && PWDATA_I[g]) begin
                                state_q[g] <= scm_pkg::SCM_IDLE;
                            end
                        end
                        default: state_q[g] <= scm_pkg::SCM_IDLE;
                    endcase
                end
            end

            // event chosen by the interrupt source bit
            assign irq_evt[g] = (state_q[g] == scm_pkg::SCM_RUN)
                & (m[scm_pkg::BIT_IRQ_SRC] ? BUF_EMPTY_I[g] : XFER_END_I[g]);

            // protocol and remaining fields exported from the register
            assign CH_CFG_O[g].clk_sel  = m[scm_pkg::BIT_CLK_SEL];
            assign CH_CFG_O[g].xfer_src = m[scm_pkg::BIT_XFER_SRC];
            assign CH_CFG_O[g].trig_src = m[scm_pkg::BIT_TRIG_SRC];
            assign CH_CFG_O[g].rx_inv   = m[scm_pkg::BIT_RX_INV];
            assign CH_CFG_O[g].protocol = m[scm_pkg::BIT_PROTO];
            assign CH_CFG_O[g].irq_src  = m[scm_pkg::BIT_IRQ_SRC];

            // transfer tick paces the channel engine
            assign CH_STAT_O[g].op_tick   = op_tick_q[g];
            assign CH_STAT_O[g].xfer_tick = xfer_tick_q[g];
            assign CH_STAT_O[g].start     = start_q[g];
            assign CH_STAT_O[g].enabled   = state_q[g] != scm_pkg::SCM_IDLE;
            assign CH_STAT_O[g].rx_data   = (g == 1) ? rx_data_q : 1'b1;
        end
    endgenerate

    // ticks registered so the engine sees clean single-cycle strobes
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            op_tick_q   <= '0;
            xfer_tick_q <= '0;
        end else begin
            op_tick_q   <= op_tick_d;
            xfer_tick_q <= xfer_tick_d;
        end
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            irq_stat_q <= '0;
        end else if (acc_wr && idx == scm_pkg::IDX_IRQCLR) begin
            irq_stat_q <= (irq_stat_q & ~PWDATA_I[NCH-1:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            irq_en_q <= '0;
        end else if (acc_wr && idx == scm_pkg::IDX_IRQEN) begin
            irq_en_q <= PWDATA_I[NCH-1:0];
        end
    end

    assign IRQ_O = |(irq_stat_q & irq_en_q);

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);

    a_mode_reset_val: assert property ($fell(RESET_I) |-> mode_q[0] == 16'h0020
        && mode_q[1] == 16'h0020) else $error("mode register reset value wrong");
    a_partial_write_drop: assert property (acc_wr && idx == scm_pkg::IDX_MODE1
        && !full_half |=> $stable(mode_q[1])) else $error("partial mode write stored");
    a_run_bits_locked: assert property (state_q[0] == scm_pkg::SCM_RUN && acc_wr
        && idx == scm_pkg::IDX_MODE0 |=> mode_q[0][15:1] == $past(mode_q[0][15:1]))
        else $error("mode rewritten while enabled");
    a_unit_off_default: assert property (!unit_en |=> mode_q[0] == 16'h0020
        && presc_q == 16'h0000) else $error("registers not default while unit off");
    a_ch0_reserved: assert property (mode_q[0][8] == 1'b0 && mode_q[0][6] == 1'b0
        && mode_q[0][5]) else $error("channel 0 reserved bits wrong");
    a_fixed_bits: assert property ((mode_q[1] & ~16'hC143) == 16'h0020)
        else $error("mode reserved bits not fixed");
    a_start_after_arm: assert property ($rose(start_q[1]) |->
        $past(state_q[1]) == scm_pkg::SCM_ARMED) else $error("start without arming");
    a_sw_trig_now: assert property (state_q[0] == scm_pkg::SCM_ARMED && !acc_wr
        |=> start_q[0] ##1 !start_q[0]) else $error("software trigger not immediate");
    a_ext_clock: assert property (unit_en && mode_q[0][14] && sck_rise
        |=> xfer_tick_q[0]) else $error("external clock edge lost");
    a_op_clk_a: assert property (unit_en && !mode_q[0][15] && presc_q[3:0] == 4'h0
        && $stable(presc_q) |=> op_tick_q[0]) else $error("undivided clock A missing");
    a_buf_empty_irq: assert property (state_q[0] == scm_pkg::SCM_RUN && mode_q[0][0]
        && BUF_EMPTY_I[0] |=> irq_stat_q[0]) else $error("buffer empty event lost");

    c_uart_rx_start: cover property (state_q[1] == scm_pkg::SCM_ARMED ##1 start_q[1]
        && mode_q[1][8]);
    c_ext_clock_run: cover property (xfer_tick_q[0] && mode_q[0][14]);
    c_irq_raised: cover property ($rose(IRQ_O));
endmodule

// >>> inc/scm_pkg.sv
// shared constants and types for the serial channel mode configuration block
package scm_pkg;
    // register indices; byte address is four times the index
    localparam int unsigned IDX_W       = 20;
    localparam logic [19:0] IDX_UNIT    = 20'hF00F0;
    localparam logic [19:0] IDX_MODE0   = 20'hF0110;
    localparam logic [19:0] IDX_MODE1   = 20'hF0112;
    localparam logic [19:0] IDX_PRESC   = 20'hF0126;
    localparam logic [19:0] IDX_START   = 20'hF0128;
    localparam logic [19:0] IDX_ENSTAT  = 20'hF012A;
    localparam logic [19:0] IDX_STOP    = 20'hF012C;
    localparam logic [19:0] IDX_DATA0   = 20'hF0130;
    localparam logic [19:0] IDX_DATA1   = 20'hF0132;
    localparam logic [19:0] IDX_IRQSTAT = 20'hF0140;
    localparam logic [19:0] IDX_IRQCLR  = 20'hF0141;
    localparam logic [19:0] IDX_IRQEN   = 20'hF0142;

    // mode register layout
    localparam logic [15:0] MODE_RESET    = 16'h0020;
    localparam logic [15:0] MODE_FIXED    = 16'h0020;
    localparam logic [15:0] MODE_MASK_CH0 = 16'hC003;
    localparam logic [15:0] MODE_MASK_CH1 = 16'hC143;
    localparam logic [15:0] MODE_RUN_MASK = 16'h0001;
    localparam int unsigned BIT_CLK_SEL   = 15;
    localparam int unsigned BIT_XFER_SRC  = 14;
    localparam int unsigned BIT_TRIG_SRC  = 8;
    localparam int unsigned BIT_RX_INV    = 6;
    localparam int unsigned BIT_PROTO     = 1;
    localparam int unsigned BIT_IRQ_SRC   = 0;

    // other register layouts and reset values
    localparam int unsigned RATIO_LSB     = 9;
    localparam int unsigned RATIO_W       = 7;
    localparam int unsigned PRESC_A_LSB   = 0;
    localparam int unsigned PRESC_B_LSB   = 4;
    localparam int unsigned PRESC_SEL_W   = 4;
    localparam int unsigned PRESC_CNT_W   = 15;
    localparam int unsigned UNIT_EN_BIT   = 2;
    localparam logic [15:0] DATA_RESET    = 16'h0000;
    localparam logic [15:0] PRESC_RESET   = 16'h0000;
    localparam logic [7:0]  UNIT_RESET    = 8'h00;
    localparam logic [3:0]  STRB_HALF     = 4'h3;

    // per-channel start sequence, gray along idle -> armed -> run
    typedef enum logic [1:0] {
        SCM_IDLE  = 2'b00,
        SCM_ARMED = 2'b01,
        SCM_RUN   = 2'b11
    } scm_chan_e;

    // decoded configuration handed to the channel engine
    typedef struct packed {
        logic clk_sel;
        logic xfer_src;
        logic trig_src;
        logic rx_inv;
        logic protocol;
        logic irq_src;
    } scm_cfg_s;

    // per-channel timing and status strobes
    typedef struct packed {
        logic op_tick;
        logic xfer_tick;
        logic start;
        logic enabled;
        logic rx_data;
    } scm_chan_s;
endpackage

// >>> verif/serial_channel_mode_config_tb_top.sv
// self-checking testbench for the serial channel mode registers
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
    $display("Error at %0t ns: got %h expected %h", $time, (a), (e)); end end
module serial_channel_mode_config_tb_top;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic                      psel = 1'b0;
    logic                      penable = 1'b0;
    logic                      pwrite = 1'b0;
    logic [31:0]               paddr = 32'h0;
    logic [31:0]               pwdata = 32'h0;
    logic [3:0]                pstrb = 4'hF;
    logic [1:0]                xend = 2'h0;
    logic [1:0]                bemp = 2'h0;
    logic                      sck = 1'b0;
    logic                      rxd = 1'b1;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    logic                      irq;
    scm_pkg::scm_cfg_s [1:0]   cfg;
    scm_pkg::scm_chan_s [1:0]  stat;
    logic [31:0]               rd;
    logic                      err;
    logic [15:0]               d;
    int                        n_fail = 0;
    int                        comparisons = 0;
    int                        nop;
    int                        nx;

    // half period of the 40 MHz clock
    always #12.5 clk = ~clk;

    // pins driven by the bench; sck is left high after its scenario and rxd is left low between the two receive scenarios
    scm_mode_regs #(.NCH(2)) DUT (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SCK_PIN_I(sck), .RXD_PIN_I(rxd), .XFER_END_I(xend), .BUF_EMPTY_I(bemp),
        .CH_CFG_O(cfg), .CH_STAT_O(stat), .IRQ_O(irq));

    // expected readback: implemented bits kept, bit 5 forced high
    function automatic logic [15:0] exp_mode(input int ch, input logic [15:0] v);
        return (v & (ch == 1 ? 16'hC143 : 16'hC003)) | 16'h0020;
    endfunction

    function automatic scm_pkg::scm_cfg_s cfg_of(input logic [15:0] m);
        return {m[15], m[14], m[8], m[6], m[1], m[0]};
    endfunction

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [19:0] idx, input logic [31:0] wd,
                       input logic [3:0] st);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {10'h0, idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [19:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, 4'hF);
    endtask

    task automatic rdchk(input logic [19:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0, 4'h0);
        `CHK(rd, e)
    endtask

    // one-cycle event pulses, then time for status and irq to settle
    task automatic pulse(input logic [1:0] xe, input logic [1:0] be);
        @(posedge clk);
        xend <= xe;
        bemp <= be;
        @(posedge clk);
        xend <= 2'h0;
        bemp <= 2'h0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // count channel 0 ticks over a 64-cycle window
    task automatic ticks;
        nop = 0;
        nx = 0;
        repeat (64) begin
            @(posedge clk);
            #1;
            if (stat[0].op_tick === 1'b1) nop++;
            if (stat[0].xfer_tick === 1'b1) nx++;
        end
    endtask

    // arm channel 1 on the receive pin, move the pin at cycle 8 and log start pulses
    task automatic rx_start(input logic [15:0] mode, input logic lvl);
        wr(scm_pkg::IDX_STOP, 32'h2);
        wr(scm_pkg::IDX_MODE1, {16'h0, mode});
        wr(scm_pkg::IDX_START, 32'h2);
        nx = 0;
        nop = 0;
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            if (k == 8) rxd <= lvl;
            #1;
            if (stat[1].start === 1'b1) begin
                nx++;
                nop = k;
            end
        end
    endtask

    initial begin
        void'($urandom(32'h97e0574e));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(scm_pkg::IDX_MODE0, 32'h0020);
        rdchk(scm_pkg::IDX_MODE1, 32'h0020);
        wr(scm_pkg::IDX_MODE1, 32'hC143);
        rdchk(scm_pkg::IDX_MODE1, 32'h0020);
        wr(scm_pkg::IDX_UNIT, 32'h4);
        // all-ones corner first, then random values with legal fixed bits
        for (int i = 0; i < 12; i++) begin
            d = (i < 2) ? 16'hFFFF : exp_mode(i % 2, 16'($urandom));
            wr((i % 2) ? scm_pkg::IDX_MODE1 : scm_pkg::IDX_MODE0, {16'h0, d});
            rdchk((i % 2) ? scm_pkg::IDX_MODE1 : scm_pkg::IDX_MODE0, exp_mode(i % 2, d));
            `CHK(cfg[i % 2], cfg_of(exp_mode(i % 2, d)))
        end
        `CHK(stat[0].rx_data, 1'b1)
        wr(scm_pkg::IDX_MODE0, 32'h0020);
        apb(1'b1, scm_pkg::IDX_MODE0, 32'h8001, 4'h1);
        `CHK(err, 1'b1)
        rdchk(scm_pkg::IDX_MODE0, 32'h0020);
        apb(1'b0, 20'h00001, 32'h0, 4'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        // clock B divides by 2, clock A by 1; ratio 1 gives 4 op ticks a transfer tick
        wr(scm_pkg::IDX_PRESC, 32'h0010);
        wr(scm_pkg::IDX_DATA0, 32'h0200);
        wr(scm_pkg::IDX_START, 32'h1);
        rdchk(scm_pkg::IDX_ENSTAT, 32'h1);
        ticks();
        `CHK(nop, 64)
        `CHK(nx, 16)
        wr(scm_pkg::IDX_MODE0, 32'h8021);
        rdchk(scm_pkg::IDX_MODE0, 32'h0021);
        wr(scm_pkg::IDX_STOP, 32'h1);
        wr(scm_pkg::IDX_MODE0, 32'h8020);
        wr(scm_pkg::IDX_START, 32'h1);
        ticks();
        `CHK(nop, 32)
        `CHK(nx, 8)
        // interrupt raised, masked, cleared, then source switched while running
        wr(scm_pkg::IDX_IRQEN, 32'h1);
        pulse(2'b01, 2'b00);
        `CHK(irq, 1'b1)
        rdchk(scm_pkg::IDX_IRQSTAT, 32'h1);
        wr(scm_pkg::IDX_IRQEN, 32'h0);
        #1;
        `CHK(irq, 1'b0)
        wr(scm_pkg::IDX_IRQCLR, 32'h1);
        wr(scm_pkg::IDX_IRQEN, 32'h1);
        pulse(2'b00, 2'b01);
        `CHK(irq, 1'b0)
        wr(scm_pkg::IDX_MODE0, 32'h8021);
        pulse(2'b00, 2'b01);
        `CHK(irq, 1'b1)
        // external serial clock: five pin rises give five transfer ticks
        wr(scm_pkg::IDX_STOP, 32'h1);
        wr(scm_pkg::IDX_MODE0, 32'h4020);
        nx = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            sck <= k[2];
            #1;
            if (stat[0].xfer_tick === 1'b1) nx++;
        end
        `CHK(nx, 5)
        // receive pin as trigger: falling start edge, then rising edge with inversion;
        // the start pulse lands three edges after the pin moves (two sync flops, one register)
        rx_start(16'h0122, 1'b0);
        `CHK(nx, 1)
        `CHK(nop, 11)
        `CHK(stat[1].enabled, 1'b1)
        `CHK(stat[1].rx_data, 1'b0)
        rx_start(16'h0162, 1'b1);
        `CHK(nx, 1)
        `CHK(nop, 11)
        `CHK(stat[1].rx_data, 1'b0)
        rdchk(scm_pkg::IDX_ENSTAT, 32'h2);
        close_out();
    end
endmodule
